// File: rtl/ssw_pkg.sv
package ssw_pkg;
    // Release delay in microseconds and the clock rate
    localparam int unsigned RELEASE_DELAY_US = 180000;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned RELEASE_CYCLES = RELEASE_DELAY_US * CLK_MHZ;
    // Internal time base: one tick per microsecond
    localparam int unsigned TICK_CYCLES = CLK_MHZ;
    // Default watchdog timeout in ticks
    localparam int unsigned WDOG_TIMEOUT_TICKS = 1600000;
    localparam logic [1:0] SYNC_IDLE = 2'h3;

    typedef enum logic [1:0] {
        SSW_HOLD = 2'b00,
        SSW_DELAY = 2'b01,
        SSW_RUN = 2'b10
    } ssw_state_t;
endpackage

// File: rtl/ssw_sync_if.sv
`timescale 1ns/1ps
interface ssw_sync_if;
    logic supply_ok;
    logic manual_reset_n;
    logic kick;
    logic kick_edge;
    modport src (output supply_ok, output manual_reset_n, output kick, output kick_edge);
    modport dst (input supply_ok, input manual_reset_n, input kick, input kick_edge);
endinterface

// File: rtl/ssw_pin_sync.sv
`timescale 1ns/1ps
module ssw_pin_sync (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic supply_ok_in,
    input wire logic manual_reset_n_in,
    input wire logic watchdog_kick_in,
    ssw_sync_if.src sync
);
    // Three stages per pin; a change counts once stages two and three agree
    logic [2:0] s0_reg, s1_reg, s2_reg;
    logic [2:0] s0_next, s1_next, s2_next;
    logic [2:0] stable_reg, stable_next;
    logic kick_edge_reg, kick_edge_next;

    always_comb begin
        s0_next = s0_reg;
        s1_next = s1_reg;
        s2_next = s2_reg;
        stable_next = stable_reg;
        kick_edge_next = 1'b0;
        if (ce_in) begin
            s0_next = {watchdog_kick_in, manual_reset_n_in, supply_ok_in};
            s1_next = s0_reg;
            s2_next = s1_reg;
            for (int i = 0; i < 3; i++) begin
                if (s1_reg[i] == s2_reg[i]) begin
                    stable_next[i] = s2_reg[i];
                end
            end
            // Both directions of the kick pin count
            kick_edge_next = stable_next[2] ^ stable_reg[2];
        end else begin
            kick_edge_next = kick_edge_reg;
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            s0_reg <= 3'h0;
            s1_reg <= 3'h0;
            s2_reg <= 3'h0;
            stable_reg <= 3'h0;
            kick_edge_reg <= 1'b0;
        end else begin
            s0_reg <= s0_next;
            s1_reg <= s1_next;
            s2_reg <= s2_next;
            stable_reg <= stable_next;
            kick_edge_reg <= kick_edge_next;
        end
    end

    assign sync.supply_ok = stable_reg[0];
    assign sync.manual_reset_n = stable_reg[1];
    assign sync.kick = stable_reg[2];
    assign sync.kick_edge = kick_edge_reg;
endmodule

// File: rtl/ssw_supervisor.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Reset low while supply under falling threshold
// - Hold reset full delay after supply rises
// - Reset held while manual reset low
// - Manual release waits full delay, then deasserts
// - Active-high output mirrors active-low output timing
// - Constant watchdog level past timeout triggers reset
// - Watchdog timer clears on reset and edges
// - Release delay is fixed 180 ms
module ssw_supervisor #(
    parameter int unsigned RELEASE_CYCLES = ssw_pkg::RELEASE_CYCLES,
    parameter int unsigned TICK_CYCLES = ssw_pkg::TICK_CYCLES,
    parameter int unsigned WDOG_TIMEOUT_TICKS = ssw_pkg::WDOG_TIMEOUT_TICKS
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic supply_ok_in,
    input wire logic manual_reset_n_in,
    input wire logic watchdog_kick_in,
    output logic reset_n_out,
    output logic reset_out
);
    ssw_sync_if sync ();

    ssw_pin_sync u_sync (
        .clk_in(clk_in),
        .rst_b_in(rst_b_in),
        .ce_in(ce_in),
        .supply_ok_in(supply_ok_in),
        .manual_reset_n_in(manual_reset_n_in),
        .watchdog_kick_in(watchdog_kick_in),
        .sync(sync.src)
    );

    ssw_pkg::ssw_state_t state_reg, state_next;
    logic [31:0] delay_reg, delay_next;
    logic [31:0] tick_reg, tick_next;
    logic [31:0] wdog_reg, wdog_next;
    logic rst_reg, rst_next;
    logic cause;
    logic tick;
    logic wdog_fire;

    // The supply comparator, with its hysteresis, sits outside; supply_ok_in is
    // high above the rising threshold and low under the falling one.
    assign cause = !sync.supply_ok || !sync.manual_reset_n;
    assign tick = (tick_reg == TICK_CYCLES - 1);
    // A floating kick pin must be held by the board, otherwise it fires here
    assign wdog_fire = (wdog_reg >= WDOG_TIMEOUT_TICKS);

    always_comb begin
        state_next = state_reg;
        delay_next = delay_reg;
        tick_next = tick_reg;
        wdog_next = wdog_reg;
        rst_next = rst_reg;
        if (ce_in) begin
            tick_next = tick ? 32'h0 : tick_reg + 32'h1;
            case (state_reg)
                ssw_pkg::SSW_HOLD: begin
                    rst_next = 1'b1;
                    wdog_next = 32'h0;
                    delay_next = 32'h0;
                    if (!cause) begin
                        state_next = ssw_pkg::SSW_DELAY;
                    end
                end
                ssw_pkg::SSW_DELAY: begin
                    rst_next = 1'b1;
                    wdog_next = 32'h0;
                    if (cause) begin
                        state_next = ssw_pkg::SSW_HOLD;
                        delay_next = 32'h0;
                    end else if (delay_reg >= RELEASE_CYCLES - 1) begin
                        state_next = ssw_pkg::SSW_RUN;
                        rst_next = 1'b0;
                        delay_next = 32'h0;
                    end else begin
                        delay_next = delay_reg + 32'h1;
                    end
                end
                ssw_pkg::SSW_RUN: begin
                    if (cause) begin
                        state_next = ssw_pkg::SSW_HOLD;
                        rst_next = 1'b1;
                        wdog_next = 32'h0;
                    end else if (wdog_fire) begin
                        // Reset pulse then the full delay; count restarts at zero
                        state_next = ssw_pkg::SSW_DELAY;
                        rst_next = 1'b1;
                        wdog_next = 32'h0;
                        delay_next = 32'h0;
                    end else if (sync.kick_edge) begin
                        wdog_next = 32'h0;
                    end else if (tick) begin
                        wdog_next = wdog_reg + 32'h1;
                    end
                end
                default: begin
                    state_next = ssw_pkg::SSW_HOLD;
                    rst_next = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state_reg <= ssw_pkg::SSW_HOLD;
            delay_reg <= 32'h0;
            tick_reg <= 32'h0;
            wdog_reg <= 32'h0;
            rst_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            delay_reg <= delay_next;
            tick_reg <= tick_next;
            wdog_reg <= wdog_next;
            rst_reg <= rst_next;
        end
    end

    assign reset_n_out = !rst_reg;
    assign reset_out = rst_reg;
endmodule

// File: bench/ssw_host_model.sv
`timescale 1ns/1ps
module ssw_host_model (
    input wire logic clk_in,
    input wire logic kick_en_in,
    input wire logic reset_n_in,
    output logic kick_out
);
    logic [1:0] ph = 2'h0;
    initial kick_out = 1'b0;
    // Unused or in reset: the pin keeps a constant level
    always @(posedge clk_in) begin
        ph <= ph + 2'h1;
        if (kick_en_in && reset_n_in && ph == 2'h0) kick_out <= #1 ~kick_out;
    end
endmodule

// File: bench/ssw_properties.sv
`timescale 1ns/1ps
module ssw_properties #(
    parameter int unsigned RELEASE_CYCLES = 20,
    parameter int unsigned TICK_CYCLES = 2,
    parameter int unsigned WDOG_TIMEOUT_TICKS = 10
) (
    input wire logic clk_in,
    input wire logic rst_b_in,
    input wire logic ce_in,
    input wire logic supply_ok_in,
    input wire logic manual_reset_n_in,
    input wire logic watchdog_kick_in,
    input wire logic reset_n_out,
    input wire logic reset_out
);
    localparam int LIM = WDOG_TIMEOUT_TICKS * TICK_CYCLES;
    logic [7:0] sm_reg, q_reg, wd_reg, sm_next, q_next, wd_next;
    logic k_reg;
    function automatic logic [7:0] sat(input logic [7:0] v);
        return v + 8'(v != 8'hff);
    endfunction
    // Idle time only counts while reset is off, as the timer is held meanwhile
    always_comb begin
        sm_next = (supply_ok_in && manual_reset_n_in) ? sat(sm_reg) : 8'h0;
        wd_next = (watchdog_kick_in != k_reg || reset_out) ? 8'h0 : (ce_in ? sat(wd_reg) : wd_reg);
        q_next = (sm_next == 8'h0 || wd_reg >= 8'd12) ? 8'h0 : sat(q_reg);
    end
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            {sm_reg, q_reg, wd_reg, k_reg} <= '0;
        end else begin
            {sm_reg, q_reg, wd_reg, k_reg} <= {sm_next, q_next, wd_next, watchdog_kick_in};
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    pair_inverse_a: assert property (reset_n_out != reset_out) else $error("outputs not inverse");
    reset_entry_a: assert property ($rose(rst_b_in) |-> reset_out) else $error("reset off after init");
    supply_low_a: assert property ((ce_in && !supply_ok_in) [*7] |-> reset_out) else $error("supply");
    manual_hold_a: assert property (!manual_reset_n_in [*7] |-> !reset_n_out) else $error("manual");
    release_min_a: assert property ($fell(reset_out) |-> sm_reg >= RELEASE_CYCLES) else $error("early");
    release_max_a: assert property (q_reg == RELEASE_CYCLES + 8 |-> !reset_out) else $error("late");
    wdog_fire_a: assert property (wd_reg <= LIM + 10) else $error("no timeout");
    wdog_clear_a: assert property ($rose(reset_out) && sm_reg > 8 |-> wd_reg >= LIM - 6) else $error("wd");
    cover property ($fell(reset_out));
    cover property (wd_reg == LIM);
    cover property (!manual_reset_n_in && reset_out);
endmodule
bind ssw_supervisor ssw_properties #(.RELEASE_CYCLES(RELEASE_CYCLES), .TICK_CYCLES(TICK_CYCLES),
    .WDOG_TIMEOUT_TICKS(WDOG_TIMEOUT_TICKS)) chk (.*);

// File: bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam int RC = 20;
    logic clk_in = 0, rst_b_in = 0, sup = 0, mrn = 1, ken = 1, ce = 1, kick, rn, r;
    logic [31:0] rs = 32'h20d0;
    int errors = 0, checks = 0, n, d;
    always #2 clk_in = ~clk_in;
    ssw_supervisor #(.RELEASE_CYCLES(RC), .TICK_CYCLES(2), .WDOG_TIMEOUT_TICKS(10)) uut (.clk_in(clk_in),
        .rst_b_in(rst_b_in), .ce_in(ce), .supply_ok_in(sup), .manual_reset_n_in(mrn),
        .watchdog_kick_in(kick), .reset_n_out(rn), .reset_out(r));
    ssw_host_model host (.clk_in(clk_in), .kick_en_in(ken), .reset_n_in(rn), .kick_out(kick));
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    function automatic logic win(input int v, input int lo, input int hi);
        return v >= lo && v <= hi;
    endfunction
    task automatic summarize;
        if (errors == 0 && checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) begin
            @(posedge clk_in);
            #1;
        end
    endtask
    task automatic chk(input string s, input logic e, input logic v);
        checks++;
        if (v !== e) begin
            errors++;
            $display("[ERR] %s exp %b got %b", s, e, v);
        end
    endtask
    task automatic wait_for(input logic lvl, output int c);
        c = 0;
        while (r !== lvl && c < 80) begin
            tick(1);
            c++;
        end
        if (c >= 80) begin
            chk("wait", 1'b1, 1'b0);
            summarize();
        end
    endtask
    initial begin
        tick(4);
        rst_b_in = 1;
        sup = 1;
        wait_for(1'b0, n);
        chk("por", 1'b1, win(n, RC, RC + 10));
        // Clock enable low freezes the watchdog, so a silent kick pin must not time out
        ce = 0;
        ken = 0;
        tick(50);
        chk("ce_freeze", 1'b0, r);
        ce = 1;
        ken = 1;
        tick(4);
        for (int i = 0; i < 14; i++) begin
            rs = xs(rs);
            d = 8 + int'(rs[5:2]);
            if (rs[1:0] == 2'h0) begin
                sup = 0;
                tick(d);
                chk("rst_n", 1'b0, rn);
                sup = 1;
            end else if (rs[1:0] == 2'h1) begin
                mrn = 0;
                tick(d);
                chk("rst", 1'b1, r);
                mrn = 1;
                // A second press inside the delay must restart it
                if (rs[6]) begin
                    tick(10);
                    mrn = 0;
                    tick(8);
                    mrn = 1;
                end
            end else begin
                ken = 0;
                wait_for(1'b1, n);
                chk("wdog", 1'b1, win(n, 10, 30));
                ken = 1;
            end
            wait_for(1'b0, n);
            chk("delay", 1'b1, win(n, RC - 2, RC + 8));
            tick(30);
            chk("kicked", 1'b0, r);
        end
        summarize();
    end
endmodule
